// [rtl/vtc_cmd.sv]
// Purpose: Serial command interpreter of the temperature unit
// Assumes: Inputs synchronous to i_ref_clk, half-duplex host
// Notes: Block check is XOR of bytes after STX through ETX
`include "vtc_defs.svh"
module vtc_cmd
  import vtc_pkg::*;
#(
  parameter int BIT_CYC = `VTC_CLK_HZ / `VTC_BAUD,
  parameter int LOG_DEPTH = `VTC_LOG_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic i_download_active,
  input wire logic i_flash_erased,
  input wire logic i_evap_option,
  input wire logic i_evap_conn,
  input wire logic i_no_gas,
  input wire logic i_overheat,
  input wire logic i_exch_conn,
  input wire logic i_ln2_refill,
  input wire logic i_ln2_empty,
  input wire logic i_booster,
  input wire logic i_ext_err_valid,
  input wire logic [3:0] i_ext_err_code,
  output logic o_ext_err_ready,
  output logic o_gas_heater_on,
  output logic o_conv_test_on,
  output logic o_n2_heater_on,
  output logic [6:0] o_n2_level
);
  localparam int CW = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYC - 1);
  localparam logic [2:0] LOG_TOP = 3'(LOG_DEPTH - 1);
  localparam logic [2:0] LOG_FULL = 3'(LOG_DEPTH);

  // Receiver: 8 data, even parity, one stop
  logic [CW-1:0] rx_cnt;
  logic [3:0] rx_bit;
  logic rx_busy;
  logic [8:0] rx_sh;
  logic rx_stb;
  logic [7:0] rx_byte;
  logic rx_perr;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_cnt <= '0;
      rx_bit <= 4'h0;
      rx_busy <= 1'b0;
      rx_sh <= 9'h000;
      rx_stb <= 1'b0;
      rx_byte <= 8'h00;
      rx_perr <= 1'b0;
    end else begin
      rx_stb <= 1'b0;
      if (!rx_busy) begin
        if (!i_rxd) begin
          rx_busy <= 1'b1;
          rx_cnt <= CW'(BIT_CYC / 2);
          rx_bit <= 4'h0;
        end
      end else if (rx_cnt != '0) begin
        rx_cnt <= rx_cnt - 1'b1;
      end else begin
        rx_cnt <= BIT_LAST;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0) begin
          if (i_rxd) rx_busy <= 1'b0;
        end else if (rx_bit < 4'hA) begin
          rx_sh <= {i_rxd, rx_sh[8:1]};
        end else begin
          rx_busy <= 1'b0;
          rx_stb <= 1'b1;
          rx_byte <= rx_sh[7:0];
          rx_perr <= (^rx_sh) | !i_rxd;
        end
      end
    end
  end

  vtc_state_t st;
  logic [7:0] cmd0, cmd1, xsum;
  logic is_wr;
  logic [1:0] bad;
  logic [2:0] n;
  logic [3:0] argn;
  logic [7:0] arg [0:`VTC_ARG_MAX-1];
  logic [7:0] tx_buf [0:9];
  logic [3:0] tx_len, tx_idx;
  logic [3:0] tx_left;
  logic tx_go;
  logic [7:0] tx_data;
  logic [CW-1:0] tx_cnt;
  logic [9:0] tx_sh;
  wire rx_ok = rx_stb && !rx_perr;
  wire rx_eot = rx_stb && rx_byte == `VTC_EOT && st != ST_CHECK;

  // Frame parser; host framing is EOT 0000 [STX] cmd arg (ETX check | ENQ)
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= ST_IDLE;
      cmd0 <= 8'h00;
      cmd1 <= 8'h00;
      xsum <= 8'h00;
      is_wr <= 1'b0;
      bad <= 2'h0;
      n <= 3'h0;
      argn <= 4'h0;
      for (int i = 0; i < `VTC_ARG_MAX; i++) arg[i] <= 8'h00;
    end else if (rx_eot && st != ST_EXEC && st != ST_SEND) begin
      st <= ST_ADDR;
      n <= 3'h0;
      bad <= 2'h0;
      is_wr <= 1'b0;
      xsum <= 8'h00;
      argn <= 4'h0;
    end else begin
      case (st)
        ST_IDLE: ;
        ST_ADDR: if (rx_stb) begin
          if (!rx_ok || rx_byte != `VTC_CH0) bad <= 2'h1;
          n <= n + 3'h1;
          if (n == 3'h3) begin
            st <= ST_HEAD;
            n <= 3'h0;
          end
        end
        ST_HEAD: if (rx_stb) begin
          if (!rx_ok) bad <= 2'h1;
          if (n == 3'h0 && !is_wr && rx_byte == `VTC_STX) begin
            is_wr <= 1'b1;
          end else begin
            xsum <= xsum ^ rx_byte;
            if (n == 3'h0) cmd0 <= rx_byte;
            else cmd1 <= rx_byte;
            n <= n + 3'h1;
            if (n == 3'h1) st <= ST_ARG;
          end
        end
        ST_ARG: if (rx_stb) begin
          if (!rx_ok) bad <= 2'h1;
          xsum <= xsum ^ rx_byte;
          if (!is_wr) begin
            if (rx_byte != `VTC_ENQ) bad <= 2'h1;
            st <= ST_EXEC;
          end else if (rx_byte == `VTC_ETX) begin
            st <= ST_CHECK;
          end else if (argn < 4'(`VTC_ARG_MAX)) begin
            arg[argn[2:0]] <= rx_byte;
            argn <= argn + 4'h1;
          end else begin
            bad <= 2'h1;
          end
        end
        ST_CHECK: if (rx_stb) begin
          if (bad == 2'h0 && (!rx_ok || rx_byte != xsum)) bad <= 2'h2;
          st <= ST_EXEC;
        end
        ST_EXEC: st <= ST_SEND;
        ST_SEND: if (tx_left == 4'h0 && !tx_go && tx_idx == tx_len) st <= ST_IDLE;
        default: st <= ST_IDLE;
      endcase
    end
  end

  // Error log storage, newest at head-1
  logic [3:0] log_mem [0:LOG_DEPTH-1];
  logic [2:0] head, log_cnt;
  wire [2:0] prev_head = (head == 3'h0) ? LOG_TOP : head - 3'h1;
  wire [3:0] log_top = (log_cnt == 3'h0) ? `VTC_ERR_NONE : log_mem[prev_head];
  wire [15:0] status_word = {5'h00, i_booster, 1'b1, o_n2_heater_on,
    i_ln2_empty, i_ln2_refill, i_exch_conn, i_overheat, i_no_gas,
    i_evap_conn, 1'b0, o_gas_heater_on};
  wire [15:0] cmd_id = {cmd0, cmd1};
  wire sel_exec = st == ST_EXEC;

  logic ex_ack, ex_data, ex_log, ex_pop, wr_gas, wr_conv, wr_n2sw, wr_n2lvl, wr_val;
  logic [3:0] ex_code;
  logic [7:0] pl [0:4];
  logic [2:0] pl_len;
  logic [6:0] lvl_val;
  logic [7:0] rsp_sum;
  always_comb begin
    logic [9:0] acc;
    logic seen, fail;
    acc = 10'h000;
    seen = 1'b0;
    fail = 1'b0;
    ex_ack = 1'b0;
    ex_data = 1'b0;
    ex_log = 1'b0;
    ex_pop = 1'b0;
    ex_code = `VTC_ERR_SYNTAX;
    wr_gas = 1'b0;
    wr_conv = 1'b0;
    wr_n2sw = 1'b0;
    wr_n2lvl = 1'b0;
    wr_val = arg[0][0];
    for (int i = 0; i < 5; i++) pl[i] = `VTC_SPC;
    pl_len = 3'h1;
    // Decimal level with leading spaces or zeros
    for (int i = 0; i < 5; i++) begin
      if (4'(i) < argn) begin
        if (arg[i] == `VTC_SPC && !seen) begin
          fail = fail;
        end else if (arg[i] >= `VTC_CH0 && arg[i] <= 8'h39) begin
          acc = 10'((acc > 10'h064 ? 10'h3FF : acc * 10'h00A) + {6'h00, arg[i][3:0]});
          seen = 1'b1;
        end else begin
          fail = 1'b1;
        end
      end
    end
    lvl_val = acc[6:0];
    wire_ok: begin end
    if (bad != 2'h0) begin
      ex_log = 1'b1;
      ex_code = (bad == 2'h2) ? `VTC_ERR_CHKSUM : `VTC_ERR_SYNTAX;
    end else begin
      case (cmd_id)
        `VTC_CMD_DOWNLOAD: if (!is_wr) begin
          ex_data = 1'b1;
          pl[0] = !i_download_active ? `VTC_CH0 : (i_flash_erased ? 8'h32 : `VTC_CH1);
        end
        `VTC_CMD_CONVTEST: if (is_wr && argn == 4'h1 && arg[0][7:1] == 7'h18) begin
          ex_ack = 1'b1;
          wr_conv = 1'b1;
        end
        `VTC_CMD_ERRLOG: if (!is_wr) begin
          ex_data = 1'b1;
          ex_pop = log_cnt != 3'h0;
          if (log_top < 4'hA) begin
            pl[0] = {4'h3, log_top};
          end else begin
            pl[0] = `VTC_CH1;
            pl[1] = {4'h3, 4'(log_top - 4'hA)};
            pl_len = 3'h2;
          end
        end
        `VTC_CMD_GASHEAT: if (!is_wr) begin
          ex_data = 1'b1;
          pl[0] = {7'h18, o_gas_heater_on};
        end else if (argn == 4'h1 && arg[0][7:1] == 7'h18) begin
          ex_ack = 1'b1;
          wr_gas = 1'b1;
        end
        `VTC_CMD_STATUS: if (!is_wr) begin
          ex_data = 1'b1;
          pl[0] = `VTC_GT;
          for (int d = 0; d < 4; d++) begin
            pl[d+1] = (status_word[15-4*d -: 4] < 4'hA) ? {4'h3, status_word[15-4*d -: 4]} :
              8'(8'h37 + {4'h0, status_word[15-4*d -: 4]});
          end
          pl_len = 3'h5;
        end else begin
          ex_log = 1'b1;
        end
        `VTC_CMD_N2LEVEL: if (i_evap_option) begin
          if (!is_wr) begin
            ex_data = 1'b1;
            pl[0] = {7'h18, o_n2_level == `VTC_LVL_MAX};
            pl[1] = {4'h3, 4'((o_n2_level % 7'd100) / 7'd10)};
            pl[2] = {4'h3, 4'(o_n2_level % 7'd10)};
            pl_len = 3'h3;
          end else if (argn != 4'h0 && argn < 4'h6 && seen && !fail && acc <= 10'h064) begin
            ex_ack = 1'b1;
            wr_n2lvl = 1'b1;
          end
        end
        `VTC_CMD_N2SWITCH: if (i_evap_option) begin
          if (!is_wr) begin
            ex_data = 1'b1;
            pl[0] = {7'h18, o_n2_heater_on};
          end else if (argn == 4'h1 && arg[0][7:1] == 7'h18) begin
            ex_ack = 1'b1;
            wr_n2sw = 1'b1;
          end
        end
        default: ex_log = 1'b1;
      endcase
    end
    // Answer check covers command, payload and ETX
    rsp_sum = cmd0 ^ cmd1 ^ `VTC_ETX;
    for (int i = 0; i < 5; i++) begin
      if (3'(i) < pl_len) rsp_sum = rsp_sum ^ pl[i];
    end
  end

  // Answer assembly and byte transmit sequencing
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 10; i++) tx_buf[i] <= 8'h00;
      tx_len <= 4'h0;
      tx_idx <= 4'h0;
      tx_go <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      tx_go <= 1'b0;
      if (sel_exec) begin
        tx_idx <= 4'h0;
        if (ex_data) begin
          tx_buf[0] <= `VTC_STX;
          tx_buf[1] <= cmd0;
          tx_buf[2] <= cmd1;
          for (int i = 0; i < 5; i++) begin
            tx_buf[3+i] <= (3'(i) < pl_len) ? pl[i] : `VTC_ETX;
          end
          tx_buf[3+pl_len] <= `VTC_ETX;
          tx_buf[4+pl_len] <= rsp_sum;
          tx_len <= 4'(5 + pl_len);
        end else begin
          tx_buf[0] <= ex_ack ? `VTC_ACK : `VTC_NACK;
          tx_len <= 4'h1;
        end
      end else if (st == ST_SEND && tx_left == 4'h0 && !tx_go && tx_idx != tx_len) begin
        tx_data <= tx_buf[tx_idx];
        tx_idx <= tx_idx + 4'h1;
        tx_go <= 1'b1;
      end
    end
  end

  // Transmitter with even parity
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_txd <= 1'b1;
      tx_sh <= 10'h3FF;
      tx_left <= 4'h0;
      tx_cnt <= '0;
    end else if (tx_go) begin
      o_txd <= 1'b0;
      tx_sh <= {1'b1, ^tx_data, tx_data};
      tx_left <= 4'hB;
      tx_cnt <= BIT_LAST;
    end else if (tx_left != 4'h0) begin
      if (tx_cnt != '0) begin
        tx_cnt <= tx_cnt - 1'b1;
      end else begin
        tx_cnt <= BIT_LAST;
        tx_left <= tx_left - 4'h1;
        if (tx_left > 4'h1) begin
          o_txd <= tx_sh[0];
          tx_sh <= {1'b1, tx_sh[9:1]};
        end
      end
    end
  end

  // Output controls, all off from power-on
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_gas_heater_on <= 1'b0;
      o_conv_test_on <= 1'b0;
      o_n2_heater_on <= 1'b0;
      o_n2_level <= `VTC_LVL_RST;
    end else if (sel_exec) begin
      if (wr_gas) o_gas_heater_on <= wr_val;
      if (wr_conv) o_conv_test_on <= wr_val;
      if (wr_n2sw) o_n2_heater_on <= wr_val;
      if (wr_n2lvl) o_n2_level <= lvl_val;
    end
  end

  // Outside errors wait while a command executes
  assign o_ext_err_ready = !sel_exec;
  wire push = sel_exec ? ex_log : i_ext_err_valid;
  wire [3:0] push_code = sel_exec ? ex_code : i_ext_err_code;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      head <= 3'h0;
      log_cnt <= 3'h0;
      for (int i = 0; i < LOG_DEPTH; i++) log_mem[i] <= 4'h0;
    end else if (push) begin
      log_mem[head] <= push_code;
      head <= (head == LOG_TOP) ? 3'h0 : head + 3'h1;
      if (log_cnt != LOG_FULL) log_cnt <= log_cnt + 3'h1;
    end else if (sel_exec && ex_pop) begin
      head <= prev_head;
      log_cnt <= log_cnt - 3'h1;
    end
  end

  chk_log_bound: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    log_cnt <= LOG_FULL) else $error("log count too high");
  chk_log_pop: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    sel_exec && bad == 2'h0 && cmd_id == `VTC_CMD_ERRLOG && !is_wr && log_cnt != 3'h0
    |=> log_cnt == $past(log_cnt) - 3'h1) else $error("error query did not pop");
  chk_log_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    sel_exec && cmd_id == `VTC_CMD_ERRLOG && is_wr
    |=> tx_len == 4'h1 && tx_buf[0] == `VTC_NACK) else $error("log write not refused");
  chk_check_log: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    sel_exec && bad == 2'h2 |=> log_mem[prev_head] == `VTC_ERR_CHKSUM
    && tx_buf[0] == `VTC_NACK) else $error("check failure not logged");
  chk_gas_cause: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $changed(o_gas_heater_on) |-> $past(sel_exec && wr_gas && cmd_id == `VTC_CMD_GASHEAT))
    else $error("gas heater changed without command");
  chk_auth_switch: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    sel_exec && !i_evap_option && cmd_id == `VTC_CMD_N2SWITCH
    |=> tx_buf[0] == `VTC_NACK && $stable(o_n2_heater_on))
    else $error("unauthorised switch command");
  chk_level_range: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_n2_level <= `VTC_LVL_MAX) else $error("level above limit");
  chk_status_const: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    status_word[1] == 1'b0 && status_word[9] && status_word[15:11] == 5'h00
    && status_word[8] == o_n2_heater_on) else $error("status constants wrong");
endmodule

// [rtl/vtc_defs.svh]
// Purpose: Constants for the unit control command handler
// Assumes: 100 MHz reference clock
// Notes: Characters are 8-bit ASCII codes
`ifndef VTC_DEFS_SVH
`define VTC_DEFS_SVH
`define VTC_CLK_HZ 100000000
`define VTC_BAUD 9600
`define VTC_LOG_DEPTH 6
`define VTC_ARG_MAX 8
`define VTC_EOT 8'h04
`define VTC_STX 8'h02
`define VTC_ETX 8'h03
`define VTC_ENQ 8'h05
`define VTC_ACK 8'h06
`define VTC_NACK 8'h15
`define VTC_CH0 8'h30
`define VTC_CH1 8'h31
`define VTC_SPC 8'h20
`define VTC_GT 8'h3E
`define VTC_LVL_MAX 7'h64
`define VTC_LVL_RST 7'h00
`define VTC_ERR_NONE 4'h0
`define VTC_ERR_SYNTAX 4'h1
`define VTC_ERR_CHKSUM 4'h2
`define VTC_ERR_ERASE 4'h3
`define VTC_ERR_PROG 4'h4
`define VTC_ERR_RECTYPE 4'h5
`define VTC_ERR_ADDR 4'h6
`define VTC_ERR_HEXSUM 4'h7
`define VTC_ERR_EOF 4'h8
`define VTC_ERR_COUNT 4'h9
`define VTC_ERR_NOAPP 4'hA
`define VTC_ERR_NOID 4'hB
`define VTC_ERR_IDSUM1 4'hC
`define VTC_ERR_IDSUM4 4'hF
`define VTC_CMD_DOWNLOAD 16'h444C
`define VTC_CMD_CONVTEST 16'h4454
`define VTC_CMD_ERRLOG 16'h4553
`define VTC_CMD_GASHEAT 16'h4850
`define VTC_CMD_STATUS 16'h4953
`define VTC_CMD_N2LEVEL 16'h4E48
`define VTC_CMD_N2SWITCH 16'h4E50
`endif

// [rtl/vtc_pkg.sv]
// Purpose: Types for the unit control command handler
// Assumes: Nothing
// Notes: One-hot frame states
package vtc_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_HEAD = 7'h04,
    ST_ARG = 7'h08,
    ST_CHECK = 7'h10,
    ST_EXEC = 7'h20,
    ST_SEND = 7'h40
  } vtc_state_t;
endpackage

// [rtl/README_unused.sv]
// Purpose: none
// Assumes: none
// Notes: none

// [verification/vtc_host.sv]
// Purpose: Host computer model on the serial command link
// Assumes: BIT_CYC clocks per bit, line idles high between frames
// Notes: Tasks are called by the bench; the model only moves characters
module vtc_host #(
  parameter int BIT_CYC = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_txd,
  output logic o_rxd
);
  timeunit 1ns;
  timeprecision 1ns;

  initial o_rxd = 1'b1;

  // Start, eight data bits LSB first, even parity, stop
  task automatic put_byte(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge i_ref_clk);
      o_rxd <= f[i];
      repeat (BIT_CYC - 1) @(posedge i_ref_clk);
    end
  endtask

  // Returns in mid stop bit so a following start bit is not missed
  task automatic get_byte(output logic [7:0] b, output bit ok);
    logic [10:0] f;
    int n;
    ok = 1'b0;
    b = 8'h00;
    n = 0;
    while (i_txd !== 1'b0 && n < 400 * BIT_CYC) begin
      @(posedge i_ref_clk);
      n++;
    end
    if (n < 400 * BIT_CYC) begin
      repeat (BIT_CYC / 2) @(posedge i_ref_clk);
      for (int i = 0; i < 11; i++) begin
        f[i] = i_txd;
        if (i < 10) begin
          repeat (BIT_CYC) @(posedge i_ref_clk);
        end
      end
      b = f[8:1];
      ok = (f[0] === 1'b0) && (f[10] === 1'b1) && (^f[9:1] === 1'b0);
    end
  endtask
endmodule

// [verification/vtc_cmd_tb_top.sv]
// Purpose: Self-checking bench for the unit control command handler
// Assumes: Short bit period in simulation, host model on the serial link
// Notes: Table rows first, then check, log, download and option cases, then reset
`include "vtc_defs.svh"
module vtc_cmd_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BC = 8;
  localparam logic [39:0] ACK = {32'h0, `VTC_ACK};
  localparam logic [39:0] NAK = {32'h0, `VTC_NACK};
  typedef struct {
    logic [15:0] cmd;
    bit wr;
    logic [39:0] arg;
    int alen;
    logic [39:0] rsp;
    int rlen;
  } vtc_row_t;
  logic clk, rstn, rxd, txd, download_on, erased, evap_opt, evap_conn, no_gas, overheat;
  logic exch, refill, empty, booster, err_valid, err_ready, gas_on, conv_on, n2_on;
  logic [3:0] err_code;
  logic [6:0] n2_level;
  int miscompares;
  int num_checks;
  vtc_row_t rows[25];

  vtc_cmd #(.BIT_CYC(BC)) i_vtc_cmd (.i_ref_clk(clk), .i_rstn(rstn), .i_rxd(rxd),
    .o_txd(txd), .i_download_active(download_on), .i_flash_erased(erased),
    .i_evap_option(evap_opt),
    .i_evap_conn(evap_conn), .i_no_gas(no_gas), .i_overheat(overheat), .i_exch_conn(exch),
    .i_ln2_refill(refill), .i_ln2_empty(empty), .i_booster(booster),
    .i_ext_err_valid(err_valid), .i_ext_err_code(err_code), .o_ext_err_ready(err_ready),
    .o_gas_heater_on(gas_on), .o_conv_test_on(conv_on), .o_n2_heater_on(n2_on),
    .o_n2_level(n2_level));
  vtc_host #(.BIT_CYC(BC)) i_vtc_host (.i_ref_clk(clk), .i_txd(txd), .o_rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic reset_seq();
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("txd idle", {15'h0, txd}, 16'h0001);
    chk("gas heater", {15'h0, gas_on}, 16'h0000);
    chk("n2 switch", {15'h0, n2_on}, 16'h0000);
    chk("n2 level", {9'h0, n2_level}, 16'h0000);
    chk("conv test", {15'h0, conv_on}, 16'h0000);
  endtask

  task automatic txn(input vtc_row_t r, input bit bad);
    logic [7:0] q[$];
    logic [7:0] e[$];
    logic [7:0] got[$];
    logic [7:0] b;
    logic [7:0] x;
    bit ok;
    q = '{`VTC_EOT, `VTC_CH0, `VTC_CH0, `VTC_CH0, `VTC_CH0};
    if (r.wr) q.push_back(`VTC_STX);
    q.push_back(r.cmd[15:8]);
    q.push_back(r.cmd[7:0]);
    for (int i = r.alen - 1; i >= 0; i--) q.push_back(r.arg[8*i+:8]);
    x = 8'h00;
    if (r.wr) begin
      q.push_back(`VTC_ETX);
      for (int i = 6; i < q.size(); i++) x ^= q[i];
      q.push_back(x ^ {7'h00, bad});
    end else begin
      q.push_back(`VTC_ENQ);
    end
    if (r.rlen == 0) begin
      e.push_back(r.rsp[7:0]);
    end else begin
      e = '{`VTC_STX, r.cmd[15:8], r.cmd[7:0]};
      for (int i = r.rlen - 1; i >= 0; i--) e.push_back(r.rsp[8*i+:8]);
      e.push_back(`VTC_ETX);
      x = 8'h00;
      for (int i = 1; i < e.size(); i++) x ^= e[i];
      e.push_back(x);
    end
    ok = 1'b1;
    fork
      foreach (q[i]) i_vtc_host.put_byte(q[i]);
      for (int i = 0; i < e.size() && ok; i++) begin
        i_vtc_host.get_byte(b, ok);
        got.push_back(b);
      end
    join
    chk("reply framing", {15'h0, ok}, 16'h0001);
    if (!ok) close_out();
    foreach (e[i]) chk("reply byte", {8'h00, got[i]}, {8'h00, e[i]});
  endtask

  task automatic push_err(input logic [3:0] c);
    @(negedge clk);
    chk("push ready", {15'h0, err_ready}, 16'h0001);
    @(posedge clk);
    err_valid <= 1'b1;
    err_code <= c;
    @(posedge clk);
    err_valid <= 1'b0;
  endtask

  initial begin
    rows[0] = '{`VTC_CMD_GASHEAT, 1'b0, 40'h0, 0, 40'h30, 1};
    rows[1] = '{`VTC_CMD_N2SWITCH, 1'b0, 40'h0, 0, 40'h30, 1};
    rows[2] = '{`VTC_CMD_N2LEVEL, 1'b0, 40'h0, 0, 40'h303030, 3};
    rows[3] = '{`VTC_CMD_ERRLOG, 1'b0, 40'h0, 0, 40'h30, 1};
    rows[4] = '{`VTC_CMD_DOWNLOAD, 1'b0, 40'h0, 0, 40'h30, 1};
    rows[5] = '{`VTC_CMD_GASHEAT, 1'b1, 40'h31, 1, ACK, 0};
    rows[6] = '{`VTC_CMD_GASHEAT, 1'b1, 40'h20, 1, NAK, 0};
    rows[7] = '{`VTC_CMD_GASHEAT, 1'b0, 40'h0, 0, 40'h31, 1};
    rows[8] = '{`VTC_CMD_N2SWITCH, 1'b1, 40'h31, 1, ACK, 0};
    rows[9] = '{`VTC_CMD_N2SWITCH, 1'b1, 40'h2031, 2, NAK, 0};
    rows[10] = '{`VTC_CMD_N2SWITCH, 1'b0, 40'h0, 0, 40'h31, 1};
    rows[11] = '{`VTC_CMD_N2LEVEL, 1'b1, 40'h2020303530, 5, ACK, 0};
    rows[12] = '{`VTC_CMD_N2LEVEL, 1'b0, 40'h0, 0, 40'h303530, 3};
    rows[13] = '{`VTC_CMD_CONVTEST, 1'b1, 40'h31, 1, ACK, 0};
    rows[14] = '{`VTC_CMD_ERRLOG, 1'b1, 40'h33, 1, NAK, 0};
    rows[15] = '{`VTC_CMD_ERRLOG, 1'b0, 40'h0, 0, 40'h30, 1};
    rows[16] = '{`VTC_CMD_STATUS, 1'b0, 40'h0, 0, 40'h3E30373535, 5};
    rows[17] = '{16'h5A5A, 1'b0, 40'h0, 0, NAK, 0};
    rows[18] = '{`VTC_CMD_STATUS, 1'b1, 40'h31, 1, NAK, 0};
    rows[19] = '{`VTC_CMD_ERRLOG, 1'b0, 40'h0, 0, 40'h31, 1};
    rows[20] = '{`VTC_CMD_ERRLOG, 1'b0, 40'h0, 0, 40'h31, 1};
    rows[21] = '{`VTC_CMD_ERRLOG, 1'b0, 40'h0, 0, 40'h30, 1};
    rows[22] = '{`VTC_CMD_N2LEVEL, 1'b1, 40'h313031, 3, NAK, 0};
    rows[23] = '{`VTC_CMD_N2LEVEL, 1'b1, 40'h313030, 3, ACK, 0};
    rows[24] = '{`VTC_CMD_N2LEVEL, 1'b0, 40'h0, 0, 40'h313030, 3};
    miscompares = 0;
    num_checks = 0;
    {download_on, erased, no_gas, exch, empty, err_valid} = 6'h00;
    {evap_opt, evap_conn, overheat, refill, booster} = 5'h1F;
    err_code = 4'h0;
    rstn = 1'b0;
    reset_seq();
    foreach (rows[i]) txn(rows[i], 1'b0);
    chk("gas heater", {15'h0, gas_on}, 16'h0001);
    chk("n2 switch", {15'h0, n2_on}, 16'h0001);
    chk("n2 level", {9'h0, n2_level}, 16'h0064);
    chk("conv test", {15'h0, conv_on}, 16'h0001);
    // Corrupted block check leaves the heater untouched
    txn('{`VTC_CMD_GASHEAT, 1'b1, 40'h30, 1, NAK, 0}, 1'b1);
    chk("gas heater", {15'h0, gas_on}, 16'h0001);
    txn('{`VTC_CMD_ERRLOG, 1'b0, 40'h0, 0, 40'h32, 1}, 1'b0);
    // Seven pushes into six places drop the oldest
    for (int c = 9; c <= 15; c++) push_err(c[3:0]);
    for (int c = 15; c >= 10; c--) begin
      txn('{`VTC_CMD_ERRLOG, 1'b0, 40'h0, 0, {24'h0, 8'h31, 8'h26 + c[7:0]}, 2}, 1'b0);
    end
    txn('{`VTC_CMD_ERRLOG, 1'b0, 40'h0, 0, 40'h30, 1}, 1'b0);
    for (int k = 1; k <= 2; k++) begin
      @(posedge clk);
      download_on <= 1'b1;
      erased <= (k == 2);
      txn('{`VTC_CMD_DOWNLOAD, 1'b0, 40'h0, 0, 40'h30 + k, 1}, 1'b0);
    end
    @(posedge clk);
    evap_opt <= 1'b0;
    txn('{`VTC_CMD_N2SWITCH, 1'b0, 40'h0, 0, NAK, 0}, 1'b0);
    txn('{`VTC_CMD_ERRLOG, 1'b0, 40'h0, 0, 40'h30, 1}, 1'b0);
    reset_seq();
    txn('{`VTC_CMD_GASHEAT, 1'b0, 40'h0, 0, 40'h30, 1}, 1'b0);
    close_out();
  end
endmodule
